// ==== logic/gp_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
module gp_timer import gp_timer_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic debugHalt,
	input wire axi_req_t axiReq,
	output axi_rsp_t axiRsp,
	input wire logic [NUM_TIMERS-1:0] captureCompareIn,
	output logic [NUM_TIMERS-1:0] captureCompareOut,
	output logic [NUM_TIMERS-1:0] captureCompareOe,
	output logic timerIrq
);
	// whole module state lives in one packed struct: one combinational copy,
	// one register; per-timer fields are indexed 0 for A and 1 for B, while
	// control, mask and status words hold one byte per timer
	typedef struct packed {
		logic [2:0] cfg;
		logic [NUM_TIMERS-1:0][3:0] mode;
		logic [15:0] ctl;
		logic [15:0] imr;
		logic [15:0] ris;
		logic [NUM_TIMERS-1:0][15:0] ilr;
		logic [NUM_TIMERS-1:0][15:0] mat;
		logic [NUM_TIMERS-1:0][15:0] cnt;
		logic [NUM_TIMERS-1:0][15:0] tv;
		logic [NUM_TIMERS-1:0][7:0] pr;
		logic [NUM_TIMERS-1:0][7:0] pre;
		logic [NUM_TIMERS-1:0] loadPend;
		logic [NUM_TIMERS-1:0] pwmLvl;
		logic [NUM_TIMERS-1:0] pinOut;
		logic [NUM_TIMERS-1:0] pinOe;
		logic [NUM_TIMERS-1:0] sync1;
		logic [NUM_TIMERS-1:0] sync2;
		logic [NUM_TIMERS-1:0] prevIn;
		logic irq;
		logic awHeld;
		logic wHeld;
		logic [ADDR_W-1:0] awAddr;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic awRdy;
		logic wRdy;
		logic arRdy;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_t;

	// load registers and counters start full, prescalers empty; ready flags
	// start low and rise on the first edge out of reset, so nothing is taken
	// while rst is still high
	localparam state_t STATE_RESET = '{
		cfg: '0, mode: '0, ctl: '0, imr: '0, ris: '0,
		ilr: {NUM_TIMERS{LOAD_RESET}}, mat: '0,
		cnt: {NUM_TIMERS{LOAD_RESET}}, tv: '0,
		pr: {NUM_TIMERS{PRESCALE_RESET}}, pre: {NUM_TIMERS{PRESCALE_RESET}},
		loadPend: '0, pwmLvl: '0, pinOut: '0, pinOe: '0,
		sync1: '0, sync2: '0, prevIn: '0, irq: 1'b0,
		awHeld: 1'b0, wHeld: 1'b0, awAddr: '0, wData: '0, wStrb: '0,
		awRdy: 1'b0, wRdy: 1'b0, arRdy: 1'b0,
		bvalid: 1'b0, bresp: RESP_OKAY, rvalid: 1'b0, rdata: '0, rresp: RESP_OKAY
	};

	// edgeHit is combinational and read only by the next-state logic
	state_t state_reg;
	state_t state_next;
	logic [NUM_TIMERS-1:0] edgeHit;

	// byte-lane merge of a write into an existing register image
	// lanes with a clear strobe keep their old contents, so narrow writes are safe
	function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// edge detect on synchronised samples; only the second stage and its delayed copy are read
	// the first stage feeds nothing but the second, so a metastable sample never
	// reaches the counters; an edge is acted on three edges after the pin moves
	genvar g;
	generate
		for (g = 0; g < NUM_TIMERS; g++) begin : gEdge
			logic riseSeen;
			logic fallSeen;
			logic [1:0] evtSel;
			assign riseSeen = state_reg.sync2[g] & ~state_reg.prevIn[g];
			assign fallSeen = ~state_reg.sync2[g] & state_reg.prevIn[g];
			assign evtSel = state_reg.ctl[g*TIMER_STRIDE+CTL_EVT +: 2];
			// unused encoding 10 matches nothing, so a stray setting cannot count
			assign edgeHit[g] = (evtSel == EVT_RISE) ? riseSeen :
				(evtSel == EVT_FALL) ? fallSeen :
				(evtSel == EVT_BOTH) ? (riseSeen | fallSeen) : 1'b0;
		end
	endgenerate

	// next-state logic: write handshakes, both timers, then register writes and reads
	// all working values are given a value first, so no latch can form
	always_comb begin
		logic [31:0] img;
		logic [31:0] rd;
		logic rdHit;
		logic doWrite;
		logic [15:0] setFlags;
		logic [15:0] clrFlags;
		logic split;
		logic run;
		logic [1:0] msel;
		logic ctype;
		logic alt;
		logic isPwm;
		logic isCount;
		logic isTime;
		logic isTimer;
		int base;
		img = '0;
		rd = '0;
		rdHit = 1'b0;
		doWrite = 1'b0;
		setFlags = '0;
		clrFlags = '0;
		split = 1'b0;
		run = 1'b0;
		msel = '0;
		ctype = 1'b0;
		alt = 1'b0;
		isPwm = 1'b0;
		isCount = 1'b0;
		isTime = 1'b0;
		isTimer = 1'b0;
		base = 0;
		// every field holds unless a branch below moves it
		state_next = state_reg;

		// capture pin synchronisers
		// load requests last a single cycle unless a write below renews them
		state_next.sync1 = captureCompareIn;
		state_next.sync2 = state_reg.sync1;
		state_next.prevIn = state_reg.sync2;
		state_next.loadPend = '0;

		// write channel: address and data may arrive in either order
		// each half is held until the write lands; its ready stays low meanwhile
		if (axiReq.awvalid && state_reg.awRdy) begin
			state_next.awHeld = 1'b1;
			state_next.awAddr = axiReq.awaddr;
		end
		if (axiReq.wvalid && state_reg.wRdy) begin
			state_next.wHeld = 1'b1;
			state_next.wData = axiReq.wdata;
			state_next.wStrb = axiReq.wstrb;
		end
		if (state_reg.bvalid && axiReq.bready) begin
			state_next.bvalid = 1'b0;
		end
		doWrite = state_reg.awHeld && state_reg.wHeld && !state_reg.bvalid;

		// timers run first so that a software write in the same cycle overrides them
		// a configuration other than split leaves both timers idle
		split = (state_reg.cfg == CFG_SPLIT);
		for (int n = 0; n < NUM_TIMERS; n++) begin
			base = n * TIMER_STRIDE;
			msel = state_reg.mode[n][1:0];
			ctype = state_reg.mode[n][MODE_CAPTYPE];
			alt = state_reg.mode[n][MODE_ALT];
			isPwm = alt && !ctype && (msel == MODE_PERIODIC);
			isCount = !alt && (msel == MODE_CAPTURE) && !ctype;
			isTime = !alt && (msel == MODE_CAPTURE) && ctype;
			isTimer = !alt && ((msel == MODE_ONESHOT) || (msel == MODE_PERIODIC));
			// debug halt freezes only while the calendar enable in timer A's byte (ctl bit CTL_CAL) is off, for either timer
			run = split && state_reg.ctl[base+CTL_EN] && !(debugHalt &&
				state_reg.ctl[base+CTL_FREEZE] && !state_reg.ctl[CTL_CAL]);
			// a new interval load is taken one cycle after its write; an idle timer
			// takes it as well, so that enable starts from the value just written
			// a running edge count keeps its progress and reloads only after a match
			if (state_reg.loadPend[n] &&
				((run && !isCount) || !state_reg.ctl[base+CTL_EN])) begin
				// preload for the next enable, or a reload while running
				state_next.cnt[n] = state_reg.ilr[n];
				state_next.pre[n] = state_reg.pr[n];
			end else if (run && isTimer) begin
				// prescaler steps first; the count moves once it is empty, so one
				// count lasts prescale plus one clocks
				if (state_reg.pre[n] != '0) begin
					state_next.pre[n] = state_reg.pre[n] - 8'h01;
				end else if (state_reg.cnt[n] == '0) begin
					state_next.cnt[n] = state_reg.ilr[n];
					state_next.pre[n] = state_reg.pr[n];
					setFlags[base+STS_TO] = 1'b1;
					if (msel == MODE_ONESHOT) begin
						state_next.ctl[base+CTL_EN] = 1'b0;
					end
				end else begin
					state_next.cnt[n] = state_reg.cnt[n] - 16'h0001;
					state_next.pre[n] = state_reg.pr[n];
				end
			end else if (run && isCount) begin
				// edges are ignored while enable is low, so a finished count stays put
				// the match test looks at the value this edge would leave behind
				if (edgeHit[n]) begin
					if ((state_reg.cnt[n] - 16'h0001) == state_reg.mat[n]) begin
						state_next.cnt[n] = state_reg.ilr[n];
						state_next.ctl[base+CTL_EN] = 1'b0;
						setFlags[base+STS_MATCH] = 1'b1;
					end else begin
						state_next.cnt[n] = state_reg.cnt[n] - 16'h0001;
					end
				end
			end else if (run && (isTime || isPwm)) begin
				// no prescaler in these modes, only the 16-bit counter moves
				// reaching zero reloads on the next step, as in the timer modes
				if (state_reg.cnt[n] == '0) begin
					state_next.cnt[n] = state_reg.ilr[n];
				end else begin
					state_next.cnt[n] = state_reg.cnt[n] - 16'h0001;
				end
				if (isTime && edgeHit[n]) begin
					// the count before this edge's step is the one held
					state_next.tv[n] = state_reg.cnt[n];
					setFlags[base+STS_CAP] = 1'b1;
				end
			end
			// pwm level follows the counter; flags stay untouched in this mode
			// the level is registered, so the pin trails the counter by one clock
			if (isPwm && run) begin
				if (state_reg.cnt[n] == state_reg.ilr[n]) begin
					state_next.pwmLvl[n] = 1'b1;
				end else if (state_reg.cnt[n] == state_reg.mat[n]) begin
					state_next.pwmLvl[n] = 1'b0;
				end
			end
			state_next.pinOut[n] = state_next.pwmLvl[n] ^ state_reg.ctl[base+CTL_INV];
			state_next.pinOe[n] = split && isPwm;
		end

		// register writes land at the edge after both halves are held and bvalid
		// rises at that same edge; unmapped offsets answer with an error and
		// change nothing, read-only offsets answer okay and change nothing
		if (doWrite) begin
			state_next.awHeld = 1'b0;
			state_next.wHeld = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp = RESP_OKAY;
			case (state_reg.awAddr)
				OFF_CONFIG: begin
					img = laneMerge({29'h0, state_reg.cfg}, state_reg.wData, state_reg.wStrb);
					state_next.cfg = img[2:0];
				end
				OFF_MODE_A, OFF_MODE_B: begin
					base = (state_reg.awAddr == OFF_MODE_A) ? 0 : 1;
					img = laneMerge({28'h0, state_reg.mode[base]}, state_reg.wData,
						state_reg.wStrb);
					state_next.mode[base] = img[3:0];
				end
				OFF_CONTROL: begin
					img = laneMerge({16'h0, state_reg.ctl}, state_reg.wData, state_reg.wStrb);
					state_next.ctl = img[15:0];
				end
				OFF_MASK: begin
					img = laneMerge({16'h0, state_reg.imr}, state_reg.wData, state_reg.wStrb);
					state_next.imr = img[15:0];
				end
				OFF_CLEAR: begin
					img = laneMerge(32'h0, state_reg.wData, state_reg.wStrb);
					clrFlags = img[15:0];
				end
				OFF_LOAD_A, OFF_LOAD_B: begin
					base = (state_reg.awAddr == OFF_LOAD_A) ? 0 : 1;
					img = laneMerge({16'h0, state_reg.ilr[base]}, state_reg.wData,
						state_reg.wStrb);
					state_next.ilr[base] = img[15:0];
					state_next.loadPend[base] = 1'b1;
				end
				OFF_MATCH_A, OFF_MATCH_B: begin
					base = (state_reg.awAddr == OFF_MATCH_A) ? 0 : 1;
					img = laneMerge({16'h0, state_reg.mat[base]}, state_reg.wData,
						state_reg.wStrb);
					state_next.mat[base] = img[15:0];
				end
				OFF_PRESCALE_A, OFF_PRESCALE_B: begin
					base = (state_reg.awAddr == OFF_PRESCALE_A) ? 0 : 1;
					img = laneMerge({24'h0, state_reg.pr[base]}, state_reg.wData,
						state_reg.wStrb);
					state_next.pr[base] = img[7:0];
				end
				OFF_RAW, OFF_MASKED, OFF_VALUE_A, OFF_VALUE_B: begin
					state_next.bresp = RESP_OKAY; // read-only, write ignored
				end
				default: begin
					state_next.bresp = RESP_SLVERR;
				end
			endcase
		end

		// sticky flags: a set in the clearing cycle survives
		// the interrupt is built from the next flags and mask, so it moves at the same edge as the flags
		state_next.ris = (state_reg.ris & ~clrFlags) | setFlags;
		state_next.irq = |(state_next.ris & state_next.imr);

		// read channel: the address is decoded at the edge it is taken and the
		// answer stands from that same edge until rready is seen
		if (state_reg.rvalid && axiReq.rready) begin
			state_next.rvalid = 1'b0;
		end
		if (axiReq.arvalid && state_reg.arRdy) begin
			rdHit = 1'b1;
			case (axiReq.araddr)
				OFF_CONFIG: rd = {29'h0, state_reg.cfg};
				OFF_MODE_A: rd = {28'h0, state_reg.mode[0]};
				OFF_MODE_B: rd = {28'h0, state_reg.mode[1]};
				OFF_CONTROL: rd = {16'h0, state_reg.ctl};
				OFF_MASK: rd = {16'h0, state_reg.imr};
				OFF_RAW: rd = {16'h0, state_reg.ris};
				OFF_MASKED: rd = {16'h0, state_reg.ris & state_reg.imr};
				OFF_CLEAR: rd = '0;
				OFF_LOAD_A: rd = {16'h0, state_reg.ilr[0]};
				OFF_LOAD_B: rd = {16'h0, state_reg.ilr[1]};
				OFF_MATCH_A: rd = {16'h0, state_reg.mat[0]};
				OFF_MATCH_B: rd = {16'h0, state_reg.mat[1]};
				OFF_PRESCALE_A: rd = {24'h0, state_reg.pr[0]};
				OFF_PRESCALE_B: rd = {24'h0, state_reg.pr[1]};
				// edge time mode shows the held capture, other modes the live count
				OFF_VALUE_A: rd = {16'h0, (state_reg.mode[0][1:0] == MODE_CAPTURE &&
					state_reg.mode[0][MODE_CAPTYPE]) ? state_reg.tv[0] : state_reg.cnt[0]};
				OFF_VALUE_B: rd = {16'h0, (state_reg.mode[1][1:0] == MODE_CAPTURE &&
					state_reg.mode[1][MODE_CAPTYPE]) ? state_reg.tv[1] : state_reg.cnt[1]};
				default: rdHit = 1'b0;
			endcase
			state_next.rvalid = 1'b1;
			state_next.rdata = rd;
			state_next.rresp = rdHit ? RESP_OKAY : RESP_SLVERR;
		end

		// ready flags registered so every bus output comes from a flop
		// they look at the next state, so a channel reopens right after its answer
		state_next.awRdy = !state_next.awHeld && !state_next.bvalid;
		state_next.wRdy = !state_next.wHeld && !state_next.bvalid;
		state_next.arRdy = !state_next.rvalid;
	end

	// single state register; clock enable low freezes everything
	// reset does not wait for the clock enable, so a frozen block still resets
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_reg <= STATE_RESET;
		end else if (clkEn) begin
			state_reg <= state_next;
		end
	end

	// outputs are plain copies of registered fields, no logic after the flops
	assign axiRsp.awready = state_reg.awRdy;
	assign axiRsp.wready = state_reg.wRdy;
	assign axiRsp.bresp = state_reg.bresp;
	assign axiRsp.bvalid = state_reg.bvalid;
	assign axiRsp.arready = state_reg.arRdy;
	assign axiRsp.rdata = state_reg.rdata;
	assign axiRsp.rresp = state_reg.rresp;
	assign axiRsp.rvalid = state_reg.rvalid;
	assign captureCompareOut = state_reg.pinOut;
	assign captureCompareOe = state_reg.pinOe;
	assign timerIrq = state_reg.irq;
endmodule
`default_nettype wire

// ==== logic/gp_timer_pkg.sv ====
package gp_timer_pkg;
	localparam int ADDR_W = 8;
	localparam int NUM_TIMERS = 2;
	// register byte offsets
	localparam logic [7:0] OFF_CONFIG = 8'h00;
	localparam logic [7:0] OFF_MODE_A = 8'h04;
	localparam logic [7:0] OFF_MODE_B = 8'h08;
	localparam logic [7:0] OFF_CONTROL = 8'h0c;
	localparam logic [7:0] OFF_MASK = 8'h18;
	localparam logic [7:0] OFF_RAW = 8'h1c;
	localparam logic [7:0] OFF_MASKED = 8'h20;
	localparam logic [7:0] OFF_CLEAR = 8'h24;
	localparam logic [7:0] OFF_LOAD_A = 8'h28;
	localparam logic [7:0] OFF_LOAD_B = 8'h2c;
	localparam logic [7:0] OFF_MATCH_A = 8'h30;
	localparam logic [7:0] OFF_MATCH_B = 8'h34;
	localparam logic [7:0] OFF_PRESCALE_A = 8'h38;
	localparam logic [7:0] OFF_PRESCALE_B = 8'h3c;
	localparam logic [7:0] OFF_VALUE_A = 8'h48;
	localparam logic [7:0] OFF_VALUE_B = 8'h4c;
	// configuration and mode encodings
	localparam logic [2:0] CFG_SPLIT = 3'h4;
	localparam logic [1:0] MODE_ONESHOT = 2'h1;
	localparam logic [1:0] MODE_PERIODIC = 2'h2;
	localparam logic [1:0] MODE_CAPTURE = 2'h3;
	localparam int MODE_CAPTYPE = 2;
	localparam int MODE_ALT = 3;
	// control layout, each timer owns one byte
	localparam int TIMER_STRIDE = 8;
	localparam int CTL_EN = 0;
	localparam int CTL_FREEZE = 1;
	localparam int CTL_EVT = 2;
	localparam int CTL_CAL = 4;
	localparam int CTL_INV = 6;
	localparam logic [1:0] EVT_RISE = 2'h0;
	localparam logic [1:0] EVT_FALL = 2'h1;
	localparam logic [1:0] EVT_BOTH = 2'h3;
	// status layout, each timer owns one byte
	localparam int STS_TO = 0;
	localparam int STS_MATCH = 1;
	localparam int STS_CAP = 2;
	// reset values and bus response codes
	localparam logic [15:0] LOAD_RESET = 16'hffff;
	localparam logic [7:0] PRESCALE_RESET = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [ADDR_W-1:0] araddr;
		logic arvalid;
		logic rready;
	} axi_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} axi_rsp_t;
endpackage

// ==== tb/gp_timer_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module gp_timer_sva import gp_timer_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic debugHalt,
	input wire axi_req_t axiReq,
	input wire axi_rsp_t axiRsp,
	input wire logic [NUM_TIMERS-1:0] captureCompareIn,
	input wire logic [NUM_TIMERS-1:0] captureCompareOut,
	input wire logic [NUM_TIMERS-1:0] captureCompareOe,
	input wire logic timerIrq
);
	// a frozen clock enable holds every flop, so checks pause with it
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst || !clkEn);
	// bus answers stand until taken, then drop
	chk_b_holds: assert property (axiRsp.bvalid && !axiReq.bready |=> axiRsp.bvalid && $stable(axiRsp.bresp))
		else $error("write answer dropped early");
	chk_r_holds: assert property (axiRsp.rvalid && !axiReq.rready |=> axiRsp.rvalid && $stable(axiRsp.rdata))
		else $error("read answer dropped early");
	chk_b_clear: assert property (axiRsp.bvalid && axiReq.bready |=> !axiRsp.bvalid)
		else $error("write answer repeated");
	chk_r_clear: assert property (axiRsp.rvalid && axiReq.rready |=> !axiRsp.rvalid)
		else $error("read answer repeated");
	chk_aw_refused: assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
		else $error("write taken while answer pending");
	chk_ar_refused: assert property (axiRsp.rvalid |-> !axiRsp.arready)
		else $error("read taken while answer pending");
	chk_r_answer: assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
		else $error("read answer late");
	chk_b_answer: assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready
		|=> ##1 axiRsp.bvalid)
		else $error("write answer late");
	chk_reset_quiet: assert property (disable iff (1'b0) rst |=> !axiRsp.bvalid && !axiRsp.rvalid
		&& !timerIrq && captureCompareOe == 2'h0)
		else $error("outputs active after reset");
endmodule
bind gp_timer gp_timer_sva chk (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
	.debugHalt(debugHalt), .axiReq(axiReq), .axiRsp(axiRsp),
	.captureCompareIn(captureCompareIn), .captureCompareOut(captureCompareOut),
	.captureCompareOe(captureCompareOe), .timerIrq(timerIrq));
`default_nettype wire

// ==== tb/ccp_source.sv ====
`timescale 1ns/10ps
`default_nettype none
module ccp_source import gp_timer_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [NUM_TIMERS-1:0] flipReq,
	output logic [NUM_TIMERS-1:0] level
);
	logic [1:0] holdCnt [NUM_TIMERS];
	// a new level stands four clocks, twice the minimum, so no edge is lost
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < NUM_TIMERS; i++) begin
			if (rst) begin
				level[i] <= 1'b0;
				holdCnt[i] <= 2'h0;
			end else if (holdCnt[i] != 2'h0) holdCnt[i] <= holdCnt[i] - 2'h1;
			else if (flipReq[i]) begin
				level[i] <= ~level[i];
				holdCnt[i] <= 2'h3;
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top import gp_timer_pkg::*;;
	logic sys_clk = 1'b0;
	logic rst, clkEn, debugHalt;
	axi_req_t axiReq;
	axi_rsp_t axiRsp;
	logic [1:0] flipReq, srcLevel, ccIn, ccOut, ccOe;
	logic timerIrq;
	logic [31:0] d, v;
	logic [1:0] r;
	int fail_count = 0;
	int comparisons = 0;
	int n, hi;
	always #2.5 sys_clk = ~sys_clk;
	// a driven pin shows the timer's level, otherwise the source's
	assign ccIn = (ccOe & ccOut) | (~ccOe & srcLevel);
	gp_timer dut (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .debugHalt(debugHalt),
		.axiReq(axiReq), .axiRsp(axiRsp), .captureCompareIn(ccIn),
		.captureCompareOut(ccOut), .captureCompareOe(ccOe), .timerIrq(timerIrq));
	ccp_source src (.sys_clk(sys_clk), .rst(rst), .flipReq(flipReq), .level(srcLevel));
	task automatic close_out;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic timeout(input int c);
		if (c >= 40) begin
			fail_count++;
			$display("unexpected wait: expected answer seen none");
			close_out();
		end
	endtask
	// each channel released at the edge it is taken
	task automatic wr(input logic [7:0] a, input logic [31:0] dat);
		n = 0;
		@(posedge sys_clk);
		axiReq.awaddr <= a;
		axiReq.awvalid <= 1'b1;
		axiReq.wdata <= dat;
		axiReq.wstrb <= 4'hf;
		axiReq.wvalid <= 1'b1;
		axiReq.bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (axiRsp.awready) axiReq.awvalid <= 1'b0;
			if (axiRsp.wready) axiReq.wvalid <= 1'b0;
		end while (axiRsp.bvalid !== 1'b1 && n < 40);
		r = axiRsp.bresp;
		axiReq.bready <= 1'b0;
		timeout(n);
	endtask
	task automatic rd(input logic [7:0] a);
		n = 0;
		@(posedge sys_clk);
		axiReq.araddr <= a;
		axiReq.arvalid <= 1'b1;
		axiReq.rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (axiRsp.arready) axiReq.arvalid <= 1'b0;
		end while (axiRsp.rvalid !== 1'b1 && n < 40);
		d = axiRsp.rdata;
		r = axiRsp.rresp;
		axiReq.rready <= 1'b0;
		timeout(n);
	endtask
	// polling by reads, bounded; a flag that never comes counts once
	task automatic poll(input string nm, input int b);
		int m;
		m = 0;
		do begin
			rd(OFF_RAW);
			m++;
		end while (d[b] !== 1'b1 && m < 300);
		check(nm, 32'h1, {31'h0, d[b]});
		if (d[b] !== 1'b1) close_out();
	endtask
	task automatic flip(input int i);
		@(posedge sys_clk);
		flipReq[i] <= 1'b1;
		@(posedge sys_clk);
		flipReq[i] <= 1'b0;
		repeat (6) @(posedge sys_clk);
	endtask
	task automatic test_reset;
		rd(OFF_LOAD_A);
		check("load A reset", 32'h0000ffff, d);
		rd(OFF_PRESCALE_B);
		check("prescale B reset", 32'h0, d);
		rd(8'h40);
		check("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
		wr(8'h40, 32'h1);
		check("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
		$display("test reset done");
	endtask
	task automatic test_oneshot;
		wr(OFF_CONFIG, {29'h0, CFG_SPLIT});
		wr(OFF_MODE_A, {30'h0, MODE_ONESHOT});
		wr(OFF_LOAD_A, 32'h40);
		wr(OFF_PRESCALE_A, 32'h3);
		wr(OFF_MASK, 32'h1);
		wr(OFF_CONTROL, 32'h1);
		// 65 counts of four clocks: a missing prescaler would be done by now
		repeat (100) @(posedge sys_clk);
		rd(OFF_RAW);
		check("no early timeout", 32'h0, d & 32'h1);
		poll("timeout A", STS_TO);
		check("irq", 32'h1, {31'h0, timerIrq});
		rd(OFF_MASKED);
		check("masked timeout", 32'h1, d);
		rd(OFF_CONTROL);
		check("one-shot stops", 32'h0, d & 32'h1);
		rd(OFF_VALUE_A);
		check("reloaded", 32'h40, d);
		wr(OFF_CLEAR, 32'h1);
		rd(OFF_RAW);
		check("timeout cleared", 32'h0, d & 32'h1);
		$display("test one-shot done");
	endtask
	task automatic test_periodic;
		wr(OFF_MASK, 32'h0);
		wr(OFF_MODE_B, {30'h0, MODE_PERIODIC});
		wr(OFF_LOAD_B, 32'h30);
		wr(OFF_CONTROL, 32'h100);
		poll("timeout B", TIMER_STRIDE + STS_TO);
		wr(OFF_CLEAR, 32'h100);
		poll("timeout B again", TIMER_STRIDE + STS_TO);
		check("masked irq", 32'h0, {31'h0, timerIrq});
		wr(OFF_CONTROL, 32'h300);
		@(posedge sys_clk);
		debugHalt <= 1'b1;
		rd(OFF_VALUE_B);
		v = d;
		rd(OFF_VALUE_B);
		check("frozen in halt", v, d);
		wr(OFF_CONTROL, 32'h310);
		rd(OFF_VALUE_B);
		check("calendar keeps running", 32'h1, {31'h0, d != v});
		wr(OFF_CONTROL, 32'h300);
		@(posedge sys_clk);
		debugHalt <= 1'b0;
		rd(OFF_VALUE_B);
		v = d;
		rd(OFF_VALUE_B);
		check("resumes", 32'h1, {31'h0, d != v});
		wr(OFF_LOAD_B, 32'h8000);
		rd(OFF_VALUE_B);
		check("new load taken", 32'h1, {31'h0, d > 32'h30 && d <= 32'h8000});
		wr(OFF_CONTROL, 32'h0);
		$display("test periodic done");
	endtask
	task automatic test_count;
		wr(OFF_MODE_A, {30'h0, MODE_CAPTURE});
		wr(OFF_LOAD_A, 32'ha);
		wr(OFF_MATCH_A, 32'h6);
		wr(OFF_CLEAR, 32'hffff);
		wr(OFF_CONTROL, {26'h0, EVT_BOTH, 2'h1});
		repeat (3) flip(0);
		rd(OFF_RAW);
		check("no match at three", 32'h0, d & 32'h2);
		repeat (3) flip(0);
		rd(OFF_RAW);
		check("match at four", 32'h2, d & 32'h2);
		rd(OFF_CONTROL);
		check("count stops", 32'h0, d & 32'h1);
		rd(OFF_VALUE_A);
		check("count reloaded", 32'ha, d);
		$display("test edge count done");
	endtask
	task automatic test_time;
		logic [1:0] ev [3];
		logic hit;
		ev = '{EVT_RISE, EVT_FALL, EVT_BOTH};
		wr(OFF_MODE_B, {29'h0, 1'b1, MODE_CAPTURE});
		wr(OFF_LOAD_B, 32'hffff);
		for (int e = 0; e < 3; e++) begin
			for (int k = 0; k < 2; k++) begin
				wr(OFF_CLEAR, 32'h400);
				wr(OFF_CONTROL, {20'h0, ev[e], 2'h1, 8'h0});
				flip(1);
				hit = ev[e] == EVT_BOTH || (ev[e] == EVT_RISE) == srcLevel[1];
				rd(OFF_RAW);
				check("capture flag", {21'h0, hit, 10'h0}, d & 32'h400);
				rd(OFF_VALUE_B);
				v = d;
				rd(OFF_VALUE_B);
				check("capture held", v, d);
			end
		end
		rd(OFF_CONTROL);
		check("keeps running", 32'h100, d & 32'h100);
		wr(OFF_CONTROL, 32'h0);
		$display("test edge time done");
	endtask
	// load 20, match 10: ten high counts in every 21
	task automatic count_high(input string nm, input int e);
		repeat (5) @(posedge sys_clk);
		check("pin driven", 32'h1, {31'h0, ccOe[0]});
		hi = 0;
		repeat (42) begin
			@(posedge sys_clk);
			if (ccOut[0] === 1'b1) hi++;
		end
		check(nm, e, hi);
	endtask
	task automatic test_pwm;
		wr(OFF_MODE_A, 32'ha);
		wr(OFF_LOAD_A, 32'h14);
		wr(OFF_MATCH_A, 32'ha);
		wr(OFF_CLEAR, 32'hffff);
		wr(OFF_CONTROL, 32'h1);
		count_high("pwm high", 20);
		wr(OFF_CONTROL, 32'h41);
		count_high("inverted high", 22);
		rd(OFF_RAW);
		check("no pwm flags", 32'h0, d & 32'hff);
		$display("test pwm done");
	endtask
	initial begin
		axiReq = '0;
		rst = 1'b1;
		clkEn = 1'b1;
		debugHalt = 1'b0;
		flipReq = 2'h0;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		test_reset();
		test_oneshot();
		test_periodic();
		test_count();
		test_time();
		test_pwm();
		close_out();
	end
endmodule
`default_nettype wire
